// >>> sac_analog_model.sv
// Analog front end facing the converter: ten input levels and one comparator.
// Assumes the testbench drives each level as a code of the high reference.
`timescale 1ns/1ps
module sac_analog_model (
  input wire logic [9:0] input_switch,
  input wire logic [11:0] dac_code,
  input wire logic [11:0] level [10],
  output logic comparator_high
);
  int unsigned sel;

  // Pins carry no pull-up, so an open switch leaves the comparator at ground.
  always_comb begin
    sel = 0;
    for (int i = 0; i < 10; i++) begin
      if (input_switch[i]) sel = i;
    end
    comparator_high = (input_switch != 10'h0) && (level[sel] >= dac_code);
  end
endmodule // sac_analog_model

// >>> sac_conv_if.sv
// Link between the register side and the successive-approximation engine.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
interface sac_conv_if;
  logic start;
  logic abort;
  logic res12;
  logic [4:0] div_last;
  logic comp_high;
  logic busy;
  logic sampling;
  logic done;
  logic [11:0] result;
  logic [11:0] dac;

  modport ctrl (
    output start,
    output abort,
    output res12,
    output div_last,
    output comp_high,
    input busy,
    input sampling,
    input done,
    input result,
    input dac
  );

  modport engine (
    input start,
    input abort,
    input res12,
    input div_last,
    input comp_high,
    output busy,
    output sampling,
    output done,
    output result,
    output dac
  );
endinterface

// >>> sac_pkg.sv
// Shared constants and types for the SAR converter control block.
// Assumes a single 40 MHz peripheral clock and an APB register port.
package sac_pkg;

  // Clock rate of the peripheral clock that feeds the block.
  localparam int unsigned CLK_HZ = 40_000_000;

  // Warm-up that software owes after powering up the converter.
  localparam int unsigned WARMUP_US = 100;
  localparam int unsigned WARMUP_CYCLES = (WARMUP_US * CLK_HZ + 999_999) / 1_000_000;

  // Byte addresses of the registers inside the 4 KiB window.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_RESULT = 12'h004;
  localparam logic [11:0] OFS_IRQ_EN = 12'h00c;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h010;

  // Field positions in the control register.
  localparam int unsigned CTRL_EXT_REF_BIT = 12;
  localparam int unsigned CTRL_ENABLE_BIT = 11;
  localparam int unsigned CTRL_DIV_LSB = 8;
  localparam int unsigned CTRL_RES_BIT = 7;
  localparam int unsigned CTRL_START_BIT = 6;
  localparam int unsigned CTRL_DONE_BIT = 5;
  localparam int unsigned CTRL_GIE_BIT = 4;
  localparam int unsigned CTRL_CHAN_LSB = 0;

  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [9:0] IRQ_EN_RESET = 10'h000;

  // Converter geometry and step timing.
  localparam int unsigned NUM_CHANNELS = 10;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned SAMPLE_STEPS = 4;
  localparam int unsigned TICKS_PER_STEP = 4;
  localparam int unsigned STEPS_8BIT = 12;
  localparam int unsigned STEPS_12BIT = 16;
  localparam logic [3:0] LSB_8BIT = 4'h4;
  localparam logic [3:0] LSB_12BIT = 4'h0;

  // Divider codes of the converter clock field.
  localparam logic [2:0] DIV_1 = 3'h0;
  localparam logic [2:0] DIV_2 = 3'h1;
  localparam logic [2:0] DIV_4 = 3'h2;
  localparam logic [2:0] DIV_8 = 3'h3;
  localparam logic [2:0] DIV_16 = 3'h5;
  localparam logic [2:0] DIV_32 = 3'h6;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_CONVERT
  } sac_phase_e;

  // Last value of the prescaler count for a divider code; reserved codes run slowest.
  function automatic logic [4:0] sac_div_last(input logic [2:0] code);
    case (code)
      DIV_1: sac_div_last = 5'h00;
      DIV_2: sac_div_last = 5'h01;
      DIV_4: sac_div_last = 5'h03;
      DIV_8: sac_div_last = 5'h07;
      DIV_16: sac_div_last = 5'h0f;
      default: sac_div_last = 5'h1f;
    endcase
  endfunction

endpackage

// >>> sac_sar_engine.sv
// Successive-approximation sequencer: prescaler, step timing and bit trials.
// Assumes the comparator answer is synchronous and valid within one step.
`timescale 1ns/1ps
module sac_sar_engine (
  input wire logic clk,
  input wire logic resetn,
  sac_conv_if.engine cv
);
  import sac_pkg::*;

  typedef struct packed {
    sac_phase_e phase;
    logic [4:0] div_last;
    logic [4:0] div_cnt;
    logic [1:0] sub;
    logic [3:0] step;
    logic [3:0] bitpos;
    logic [3:0] lsb;
    logic [11:0] code;
    logic [11:0] result;
    logic done;
  } sac_eng_s;

  sac_eng_s r;
  sac_eng_s next_r;
  logic tick;
  logic step_end;

  // A tick is one period of the divided clock; a step is four ticks.
  assign tick = (r.div_cnt == r.div_last);
  assign step_end = tick && (r.sub == 2'(TICKS_PER_STEP - 1));

  // Sequencer: four sampling steps, then one step per result bit.
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (r.phase != SAC_IDLE) begin
      next_r.div_cnt = tick ? 5'h00 : r.div_cnt + 5'h01; // see (R3)
      next_r.sub = tick ? r.sub + 2'h1 : r.sub;
    end
    case (r.phase)
      SAC_IDLE: begin
        if (cv.start) begin
          next_r.phase = SAC_SAMPLE;
          next_r.div_last = cv.div_last; // see (R3)
          next_r.lsb = cv.res12 ? LSB_12BIT : LSB_8BIT; // see (R9)
          next_r.div_cnt = 5'h00;
          next_r.sub = 2'h0;
          next_r.step = 4'h0;
        end
      end
      SAC_SAMPLE: begin
        if (step_end) begin
          next_r.step = r.step + 4'h1;
          if (r.step == 4'(SAMPLE_STEPS - 1)) begin
            next_r.phase = SAC_CONVERT;
            next_r.bitpos = 4'(RESULT_W - 1);
            next_r.code = 12'h800;
          end
        end
      end
      SAC_CONVERT: begin
        if (step_end) begin
          // Keep the trial bit only while the input sits at or above the trial level.
          if (!cv.comp_high) begin
            next_r.code[r.bitpos] = 1'b0; // see (R15)
          end
          if (r.bitpos == r.lsb) begin
            next_r.phase = SAC_IDLE; // see (R1) see (R2)
            next_r.done = 1'b1;
            next_r.result = next_r.code; // see (R14)
          end else begin
            next_r.bitpos = r.bitpos - 4'h1;
            next_r.code[r.bitpos - 4'h1] = 1'b1;
          end
        end
      end
      default: next_r.phase = SAC_IDLE;
    endcase
    // An abort drops the conversion at once and reports nothing.
    if (cv.abort) begin
      next_r.phase = SAC_IDLE;
      next_r.done = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign cv.busy = (r.phase != SAC_IDLE);
  assign cv.sampling = (r.phase == SAC_SAMPLE);
  assign cv.done = r.done;
  assign cv.result = r.result;
  assign cv.dac = r.code;

endmodule // sac_sar_engine

// >>> sar_adc_control.sv
// Functional notes
// (R1) 8-bit conversion lasts 12 steps of four divided clock periods each.
// (R2) 12-bit conversion lasts 16 steps of four divided clock periods each.
// (R3) Divider codes 000..011 give 1,2,4,8; 101 gives 16, 110 gives 32.
// (R4) Enable bit 11 powers the converter up when 1 and down when 0.
// (R5) Software waits 100 us after enabling before the first start.
// (R6) Bit 12 selects the external high reference instead of the supply.
// (R7) Channel codes 0 to 9 route analog inputs 0 to 9; others reserved.
// (R8) Bit 4 connects the selected channel; clear disconnects all channels.
// (R9) Bit 7 chooses 8-bit conversion at 0 and 12-bit at 1.
// (R10) Writing start 1 begins, writing 0 stops; hardware clears it at the end.
// (R11) Done flag clears when start is set and sets when conversion ends.
// (R12) Software polls the done flag or uses the converter interrupt.
// (R13) Completion raises the interrupt only for channels whose enable bit is set.
// (R14) Result sits in bits 11:0; an 8-bit result fills bits 11 down to 4.
// (R15) Result is straight binary, code k meaning k/4096 of the reference.
// (R16) Result content is not meaningful until a conversion has completed.
// (R17) Software configures the selected pin as input without pull-up.
// (R18) For 9 to 11 bits, convert at 12 bits and drop low bits.
// (R19) Result updates in the same cycle that the done flag rises.
//
// Top of the SAR converter control: APB slave, control and result registers,
// per-channel completion interrupts and the analog front-end controls.
// Assumes an APB master on clk and an analog core that answers the trial level.
`timescale 1ns/1ps
module sar_adc_control (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_high,
  output logic irq,
  output logic converter_power,
  output logic ext_reference_select,
  output logic [sac_pkg::NUM_CHANNELS-1:0] input_switch,
  output logic sample_hold,
  output logic [sac_pkg::RESULT_W-1:0] dac_code
);
  import sac_pkg::*;

  // Control register fields, kept apart so each can be steered on its own.
  typedef struct packed {
    logic ext_ref;
    logic enable;
    logic [2:0] divider;
    logic res12;
    logic start;
    logic done;
    logic gie;
    logic [3:0] chan;
  } sac_ctrl_s;

  // All state of the register side in one record.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    sac_ctrl_s ctrl;
    logic [11:0] result;
    logic [9:0] irq_en;
    logic [9:0] irq_stat;
    logic [3:0] conv_chan;
    logic start_pulse;
    logic abort_pulse;
    logic irq;
    logic power;
    logic ext_ref_out;
    logic [9:0] switches;
  } sac_top_s;

  sac_top_s r;
  sac_top_s next_r;
  sac_conv_if cv ();

  logic setup;
  logic access_done;
  logic wr_ctrl;
  logic rd_stat;
  logic [31:0] ctrl_word;
  logic [9:0] done_set;

  // Packs the control fields into the register image, reserved bits zero.
  function automatic logic [31:0] ctrl_image(input sac_ctrl_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTRL_EXT_REF_BIT] = c.ext_ref;
    w[CTRL_ENABLE_BIT] = c.enable;
    w[CTRL_DIV_LSB +: 3] = c.divider;
    w[CTRL_RES_BIT] = c.res12;
    w[CTRL_START_BIT] = c.start;
    w[CTRL_DONE_BIT] = c.done;
    w[CTRL_GIE_BIT] = c.gie;
    w[CTRL_CHAN_LSB +: 4] = c.chan;
    return w;
  endfunction

  // One-hot channel decode; reserved codes select nothing.
  function automatic logic [9:0] chan_onehot(input logic [3:0] chan);
    logic [9:0] v;
    v = 10'h000;
    if (chan < 4'(NUM_CHANNELS)) begin
      v[chan] = 1'b1; // see (R7)
    end
    return v;
  endfunction

  // Zero-wait APB: read data and the error answer are prepared at the setup
  // edge, so the access phase always finds pready high on its first cycle.
  assign setup = psel && !penable && !r.pready;
  assign access_done = psel && penable && r.pready;
  assign wr_ctrl = access_done && pwrite && (paddr == OFS_CTRL);
  assign rd_stat = access_done && !pwrite && (paddr == OFS_IRQ_STAT);
  assign ctrl_word = ctrl_image(r.ctrl);

  // A finished conversion marks the channel it was started on.
  assign done_set = cv.done ? chan_onehot(r.conv_chan) : 10'h000;

  // Register side of the converter; the engine sees these flops and the raw comparator input.
  assign cv.start = r.start_pulse;
  assign cv.abort = r.abort_pulse;
  assign cv.res12 = r.ctrl.res12;
  assign cv.div_last = sac_div_last(r.ctrl.divider);
  assign cv.comp_high = comparator_high;

  // Next-state logic for the bus slave, the registers and the front-end.
  always_comb begin
    next_r = r;
    next_r.start_pulse = 1'b0;
    next_r.abort_pulse = 1'b0;

    // Bus answer: decode on the setup cycle, release after the access edge.
    if (setup) begin
      next_r.pready = 1'b1;
      next_r.pslverr = 1'b0;
      next_r.prdata = 32'h0000_0000;
      if (paddr == OFS_CTRL) begin
        next_r.prdata = ctrl_word;
      end else if (paddr == OFS_RESULT) begin
        next_r.prdata = {20'h00000, r.result}; // see (R14)
      end else if (paddr == OFS_IRQ_EN) begin
        next_r.prdata = {22'h000000, r.irq_en};
      end else if (paddr == OFS_IRQ_STAT) begin
        next_r.prdata = {22'h000000, r.irq_stat};
      end else begin
        next_r.pslverr = 1'b1;
      end
    end else if (access_done) begin
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
    end

    // End of conversion: start falls, done rises and the result lands together.
    if (cv.done) begin
      next_r.ctrl.start = 1'b0; // see (R10)
      next_r.ctrl.done = 1'b1; // see (R11)
      next_r.result = cv.result; // see (R19)
    end

    // Control register write. The done flag is hardware-owned and ignores writes.
    if (wr_ctrl) begin
      next_r.ctrl.ext_ref = pwdata[CTRL_EXT_REF_BIT]; // see (R6)
      next_r.ctrl.enable = pwdata[CTRL_ENABLE_BIT]; // see (R4)
      next_r.ctrl.divider = pwdata[CTRL_DIV_LSB +: 3]; // see (R3)
      next_r.ctrl.res12 = pwdata[CTRL_RES_BIT]; // see (R9)
      next_r.ctrl.gie = pwdata[CTRL_GIE_BIT]; // see (R8)
      next_r.ctrl.chan = pwdata[CTRL_CHAN_LSB +: 4]; // see (R7)
      if (pwdata[CTRL_START_BIT] && pwdata[CTRL_ENABLE_BIT]) begin
        // A second start while one runs is ignored rather than restarting.
        if (!r.ctrl.start || cv.done) begin
          next_r.ctrl.start = 1'b1; // see (R10)
          next_r.ctrl.done = 1'b0; // see (R11)
          next_r.start_pulse = 1'b1;
          next_r.conv_chan = pwdata[CTRL_CHAN_LSB +: 4];
        end
      end else if (r.ctrl.start && !cv.done) begin
        // Writing start 0, or powering down, stops the running conversion.
        next_r.ctrl.start = 1'b0; // see (R10)
        next_r.abort_pulse = 1'b1;
      end
    end

    // Channel interrupt enables mask which status bits reach the interrupt line; the status register itself is unmasked.
    if (access_done && pwrite && (paddr == OFS_IRQ_EN)) begin
      next_r.irq_en = pwdata[9:0];
    end

    // Sticky completion status. A read clears only the bits it reported, and a
    // completion landing on the clearing edge still sets its bit.
    next_r.irq_stat = (r.irq_stat & ~(rd_stat ? r.prdata[9:0] : 10'h000)) | done_set;

    // The single interrupt line rises on the same edge as the status bit it reports.
    next_r.irq = |(next_r.irq_stat & next_r.irq_en); // see (R13)

    // Front-end controls, registered so that the pins change cleanly.
    next_r.power = next_r.ctrl.enable; // see (R4)
    next_r.ext_ref_out = next_r.ctrl.ext_ref; // see (R6)
    next_r.switches = next_r.ctrl.gie ? chan_onehot(next_r.ctrl.chan) : 10'h000; // see (R8)
  end

  // State register for the whole register side.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.ctrl <= sac_ctrl_s'(CTRL_RESET[12:0]);
      r.result <= RESULT_RESET;
      r.irq_en <= IRQ_EN_RESET;
    end else begin
      r <= next_r;
    end
  end

  // The engine times the steps and runs the bit trials.
  sac_sar_engine u_engine (
    .clk(clk),
    .resetn(resetn),
    .cv(cv.engine)
  );

  // Outputs straight from flops of the register side or of the engine, except sample_hold, which decodes the engine phase.
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign converter_power = r.power;
  assign ext_reference_select = r.ext_ref_out;
  assign input_switch = r.switches;
  assign sample_hold = cv.sampling;
  assign dac_code = cv.dac;

endmodule // sar_adc_control

// >>> sar_adc_control_checker.sv
// Concurrent checks on the ports of the converter control top.
// Assumes the single clock clk and the asynchronous active-low resetn.
`timescale 1ns/1ps
module sac_ctl_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic comparator_high,
  input wire logic irq,
  input wire logic converter_power,
  input wire logic ext_reference_select,
  input wire logic [sac_pkg::NUM_CHANNELS-1:0] input_switch,
  input wire logic sample_hold,
  input wire logic [sac_pkg::RESULT_W-1:0] dac_code
);
  import sac_pkg::*;
  logic ctl_wr;
  logic ctl_rd;
  logic stat_rd;
  logic [9:0] sw_exp;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Completed accesses and the switch pattern a control write asks for.
  assign ctl_wr = psel && penable && pready && pwrite && (paddr == OFS_CTRL);
  assign ctl_rd = psel && penable && pready && !pwrite && (paddr == OFS_CTRL);
  assign stat_rd = psel && penable && pready && !pwrite && (paddr == OFS_IRQ_STAT);
  assign sw_exp = (pwdata[4] && pwdata[3:0] < 4'ha) ? (10'h1 << pwdata[3:0]) : 10'h0;

  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("access phase without ready");
  power_follow_a: assert property (ctl_wr |-> ##2 converter_power == $past(pwdata[11], 2))
    else $error("power does not follow enable bit");
  ext_ref_a: assert property (ctl_wr |-> ##2 ext_reference_select == $past(pwdata[12], 2))
    else $error("reference select does not follow");
  switch_route_a: assert property (ctl_wr |-> ##2 input_switch == $past(sw_exp, 2))
    else $error("input switch routing wrong");
  sample_len_a: assert property ($rose(sample_hold) |-> sample_hold[*8])
    else $error("sampling phase too short");
  first_trial_a: assert property ($fell(sample_hold) && $past(resetn) && converter_power |-> ##[0:1] dac_code == 12'h800)
    else $error("first trial is not mid scale");
  stat_clear_a: assert property (stat_rd && prdata[9:0] != 10'h0 && !sample_hold |-> ##2 !irq)
    else $error("irq stays after status read");
  done_idle_a: assert property (ctl_rd && prdata[5] |-> !sample_hold)
    else $error("done shown while sampling");
  start_done_a: assert property (ctl_rd && prdata[6] |-> !prdata[5])
    else $error("start and done both set");
  power_off_a: assert property ($fell(converter_power) |-> ##[0:3] !sample_hold)
    else $error("sampling while powered down");
endmodule // sac_ctl_checker

bind sar_adc_control sac_ctl_checker chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .comparator_high(comparator_high), .irq(irq),
  .converter_power(converter_power), .ext_reference_select(ext_reference_select),
  .input_switch(input_switch), .sample_hold(sample_hold), .dac_code(dac_code));

// >>> tb_top.sv
// Self-checking bench for the converter control: APB master, analog model, checks.
// Assumes the package constants and a 40 MHz clock.
`timescale 1ns/1ps
module tb_top;
  import sac_pkg::*;
  typedef struct {logic [2:0] code; logic res; logic [3:0] chan; int unsigned div;} sac_row_s;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, comparator_high, irq;
  logic converter_power, ext_reference_select, sample_hold, last_err;
  logic [11:0] paddr;
  logic [11:0] dac_code;
  logic [11:0] level [10];
  logic [31:0] pwdata, prdata;
  logic [9:0] input_switch;
  int bad_count, checks, cyc;
  sac_row_s rows [8] = '{'{3'h0, 1'b0, 4'h0, 1}, '{3'h1, 1'b1, 4'h9, 2}, '{3'h2, 1'b0, 4'h4, 4},
    '{3'h3, 1'b1, 4'h5, 8}, '{3'h4, 1'b0, 4'h6, 32}, '{3'h5, 1'b1, 4'h7, 16},
    '{3'h6, 1'b0, 4'h8, 32}, '{3'h7, 1'b1, 4'h1, 32}};

  sar_adc_control dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_high(comparator_high), .irq(irq),
    .converter_power(converter_power), .ext_reference_select(ext_reference_select),
    .input_switch(input_switch), .sample_hold(sample_hold), .dac_code(dac_code));
  sac_analog_model ana (.input_switch(input_switch), .dac_code(dac_code), .level(level),
    .comparator_high(comparator_high));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the request is held until ready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    cmp(r, exp, "read data");
    cmp(last_err, e, "slave error");
  endtask

  // Runs one conversion; irq is checked at the exact cycle it must rise.
  task automatic conv(input logic [31:0] ctl, input int unsigned div, input logic ie);
    int unsigned n;
    logic [11:0] lv;
    logic [9:0] sw;
    n = (ctl[7] ? 16 : 12) * 4 * div;
    sw = (ctl[4] && ctl[3:0] < 4'ha) ? (10'h1 << ctl[3:0]) : 10'h0;
    lv = (sw != 10'h0) ? level[ctl[3:0]] : 12'h000;
    if (!ctl[7]) lv[3:0] = 4'h0;
    wr(OFS_CTRL, ctl);
    for (int c = 1; c <= n + 4; c++) begin
      @(posedge clk);
      if (c == 8) cmp(input_switch, sw, "switch");
      if (c >= n + 2) cmp(irq, ie && c >= n + 3, "irq timing");
    end
    rd(OFS_CTRL, (ctl & ~32'h40) | 32'h20, 1'b0);
    rd(OFS_RESULT, lv, 1'b0);
    rd(OFS_IRQ_STAT, 32'h1 << ctl[3:0], 1'b0);
    repeat (3) @(posedge clk);
    cmp(irq, 1'b0, "irq clear");
    cmp(ext_reference_select, ctl[12], "ext ref");
  endtask

  // A hang is cut short well beyond the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    resetn = 1'b0;
    for (int i = 0; i < 10; i++) level[i] = 12'(i * 455);
    level[9] = 12'hfff;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_CTRL, CTRL_RESET, 1'b0);
    wr(OFS_IRQ_EN, 32'h3ff);
    wr(OFS_CTRL, 32'h800);
    repeat (WARMUP_CYCLES) @(posedge clk);
    foreach (rows[i]) conv(32'h850 | (32'(rows[i].res) << 7) | (32'(rows[i].res) << 12)
      | (32'(rows[i].code) << 8) | 32'(rows[i].chan), rows[i].div, 1'b1);
    // Masked channel with inputs disconnected: status still sets, result is zero.
    wr(OFS_IRQ_EN, 32'h0);
    conv(32'h8c2, 1, 1'b0);
    rd(12'h008, 32'h0, 1'b1);
    wr(OFS_RESULT, 32'hfff);
    rd(OFS_RESULT, 32'h0, 1'b0);
    // Abort mid conversion by clearing start, then power down.
    wr(OFS_CTRL, 32'hb50);
    repeat (100) @(posedge clk);
    rd(OFS_CTRL, 32'hb50, 1'b0);
    repeat (100) @(posedge clk);
    wr(OFS_CTRL, 32'hb10);
    repeat (500) @(posedge clk);
    rd(OFS_CTRL, 32'hb10, 1'b0);
    rd(OFS_IRQ_STAT, 32'h0, 1'b0);
    wr(OFS_CTRL, 32'h050);
    rd(OFS_CTRL, 32'h010, 1'b0);
    // Second reset while powered up but idle returns every register to zero.
    wr(OFS_CTRL, 32'h810);
    repeat (5) @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    cmp(converter_power, 1'b0, "power after reset");
    rd(OFS_CTRL, CTRL_RESET, 1'b0);
    rd(OFS_RESULT, 32'h0, 1'b0);
    rd(OFS_IRQ_EN, 32'h0, 1'b0);
    wrap_up();
  end
endmodule // tb_top
